/* File: port_e_ctl_pkg.sv */
// shared constants, types and decoders for the port e pin function block
package port_e_ctl_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_PORT_B_DIR = 8'h03;
  localparam logic [7:0] IDX_PIN_FUNC_SEL = 8'h0a;
  localparam logic [7:0] IDX_PORT_E_DATA = 8'h10;
  localparam logic [7:0] IDX_PORT_E_DIR = 8'h11;
  localparam logic [7:0] IDX_MODE_CTL = 8'h12;
  localparam logic [7:0] IDX_FUNC_MODE_PAIR = 8'h13;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SEL_NO_DBE = 7;
  localparam int SEL_CLK_TEST = 6;
  localparam int SEL_PIPE_OUT = 5;
  localparam int SEL_NO_ECLK = 4;
  localparam int SEL_LOW_STRB = 3;
  localparam int SEL_RW_EN = 2;
  localparam int MC_EMULATE = 7;
  localparam int MC_INTERNAL_VISIBILITY = 3;
  localparam int MC_E_STRETCH_SELECT = 2;
  localparam int MC_PULLUP = 0;
  localparam logic [7:0] SEL_IMPL_MASK = 8'hfc;
  localparam logic [7:0] SEL_ONCE_MASK = 8'hec;
  localparam logic [7:0] MC_IMPL_MASK = 8'h8d;
  localparam logic [7:0] PE_INPUT_ONLY = 8'h03;
  localparam logic [7:0] PE_SOFT_PULL = 8'h8e;
  localparam logic [7:0] PE_HARD_PULL = 8'h01;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SEL_RST_NORM_SINGLE = 8'h90;
  localparam logic [7:0] SEL_RST_SPEC_SINGLE = 8'h80;
  localparam logic [7:0] SEL_RST_NORM_EXP = 8'h80;
  localparam logic [7:0] SEL_RST_SPEC_EXP = 8'h2c;
  localparam logic [7:0] SEL_RST_PERIPH = 8'h00;
  localparam logic [7:0] MC_RST = 8'h01;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // ----------------------------------------------------------------
  // mode pin codes {normal_n_special, mode_select_hi, mode_select_lo}
  // ----------------------------------------------------------------
  localparam logic [2:0] MP_SPEC_SINGLE = 3'h0;
  localparam logic [2:0] MP_SPEC_NARROW = 3'h1;
  localparam logic [2:0] MP_PERIPH = 3'h2;
  localparam logic [2:0] MP_SPEC_WIDE = 3'h3;
  localparam logic [2:0] MP_NORM_NARROW = 3'h5;
  localparam logic [2:0] MP_NORM_WIDE = 3'h7;
  localparam logic [1:0] START_CYCLES = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic single;
    logic expanded;
    logic special;
    logic narrow;
    logic periph;
  } op_mode_t;

  typedef struct packed {
    logic data_en;
    logic pipe_hi;
    logic pipe_lo;
    logic e_clock;
    logic rw;
    logic low_strobe;
    logic clk_test;
  } bus_ctl_t;

  // decodes the latched mode pins; unused codes fall back to normal single-chip
  function automatic op_mode_t decode_mode(input logic [2:0] pins);
    op_mode_t m;
    m = '0;
    case (pins)
      MP_SPEC_SINGLE: begin m.single = 1'b1; m.special = 1'b1; end
      MP_SPEC_NARROW: begin m.expanded = 1'b1; m.special = 1'b1; m.narrow = 1'b1; end
      MP_PERIPH: begin m.periph = 1'b1; m.special = 1'b1; end
      MP_SPEC_WIDE: begin m.expanded = 1'b1; m.special = 1'b1; end
      MP_NORM_NARROW: begin m.expanded = 1'b1; m.narrow = 1'b1; end
      MP_NORM_WIDE: begin m.expanded = 1'b1; end
      default: begin m.single = 1'b1; end
    endcase
    return m;
  endfunction : decode_mode

  // pin function select value taken right after reset in each mode
  function automatic logic [7:0] sel_reset_value(input op_mode_t m);
    if (m.periph) begin
      return SEL_RST_PERIPH;
    end else if (m.single) begin
      return m.special ? SEL_RST_SPEC_SINGLE : SEL_RST_NORM_SINGLE;
    end else begin
      return m.special ? SEL_RST_SPEC_EXP : SEL_RST_NORM_EXP;
    end
  endfunction : sel_reset_value

endpackage : port_e_ctl_pkg

/* File: port_e_bus_control_pin_assign.sv */
// port b direction, port e data/direction and pin function select with wishbone access
//
// Overview of operation
// - port b direction bit 1 drives pin, 0 makes it a high-impedance input.
// - port b direction register leaves the map in expanded and peripheral modes.
// - unselected port e pins are gpio; select picks function, direction sets direction.
// - one bit enables pullups on inputs 7,3,2,1; pin 0 always pulled up.
// - port e data absent in peripheral mode and expanded modes with emulation set.
// - port e bits 1 and 0 never outputs; their levels always readable.
// - port e direction absent in peripheral mode and expanded modes with emulation set.
// - a selected bus-control function overrides the pin's direction bit.
// - reset value follows mode; normal single-chip all gpio, special single-chip e clock only.
// - normal expanded resets e clock only; special expanded adds data enable, pipes, rw, low strobe.
// - in peripheral mode the select register is neither readable nor writable.
// - enable bits take first write only in normal modes, all but first in special.
// - data-enable select 1 makes pin 7 gpio, 0 makes it memory data enable in expanded modes.
// - clock test bit drives pin 6 outside single-chip and normal expanded; pipes override.
// - pipe bit outside single-chip makes pins 6 and 5 queue status outputs.
// - no-e-clock bit stays 0 in expanded; once normal single, anytime special single.
// - single-chip pin 4 is e clock only if enabled and visibility on or stretch off.
// - one 16-bit write updates select register and mode register together.
// - low strobe bit drives pin 3 strobe, not in single-chip, peripheral or normal narrow.
// - tool drives pin 3 in special expanded tagging; 0 at e fall tags low byte.
// - emulation bit moves port e data and direction to external bus in expanded modes.
// - rw enable bit makes pin 2 the read/write output when 1 outside single-chip, gpio otherwise.
`timescale 1ns/1ns
module port_e_bus_control_pin_assign
  import port_e_ctl_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [9:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  output logic ERR_O,
  output logic EXT_ACCESS,
  input wire logic [2:0] MODE_PINS,
  input wire bus_ctl_t BUS_CTL,
  input wire logic TAG_ENABLE,
  input wire logic [7:0] PE_IN,
  output logic [7:0] PE_OUT,
  output logic [7:0] PE_OE,
  output logic [7:0] PE_PULLUP,
  output logic [7:0] PB_DIR_OE,
  output logic LOW_TAG
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [2:0] mode_meta_q;
  logic [2:0] mode_sync_q;
  logic [1:0] start_cnt_q;
  logic mode_valid_q;
  op_mode_t mode_q;
  logic load_init;
  logic [7:0] pe_meta_q;
  logic [7:0] pe_sync_q;
  logic [7:0] pb_dir_q;
  logic [7:0] sel_q;
  logic sel_written_q;
  logic [7:0] mc_q;
  logic [7:0] pe_data_q;
  logic [7:0] pe_dir_q;
  logic ack_q;
  logic err_q;
  logic ext_q;
  logic [31:0] rdata_q;
  logic req;
  logic [7:0] idx;
  logic hit_pb_dir;
  logic hit_sel;
  logic hit_pe_data;
  logic hit_pe_dir;
  logic hit_mc;
  logic hit_pair;
  logic known;
  logic mapped;
  logic wr;
  logic pe_regs_on;
  logic [7:0] alt_en;
  logic [7:0] alt_out;
  logic [7:0] alt_oe;
  logic [7:0] pe_oe_d;
  logic [7:0] pe_out_d;
  logic [7:0] pe_read;
  logic pipe_on;
  logic clk_test_on;
  logic eclk_on;
  logic strobe_on;
  logic tag_mode;
  logic e_prev_q;
  logic [7:0] pe_out_q;
  logic [7:0] pe_oe_q;
  logic [7:0] pe_pull_q;
  logic [7:0] pb_oe_q;
  logic tag_q;

  // next select value for a write attempt: write-once / all-but-first per mode
  function automatic logic [7:0] sel_write(input logic [7:0] old, input logic [7:0] val,
                                           input logic written, input op_mode_t m);
    logic [7:0] mask;
    logic [7:0] nxt;
    mask = '0;
    if (m.special) begin
      mask = written ? SEL_ONCE_MASK : '0;
    end else begin
      mask = written ? '0 : SEL_ONCE_MASK;
    end
    if (m.single) begin
      mask[SEL_NO_ECLK] = m.special | ~written;
    end
    nxt = ((old & ~mask) | (val & mask)) & SEL_IMPL_MASK;
    if (m.expanded) begin
      nxt[SEL_NO_ECLK] = 1'b0;
    end
    return nxt;
  endfunction : sel_write

  // ----------------------------------------------------------------
  // mode capture and pin synchronisers
  // ----------------------------------------------------------------
  // mode pins pass two flops, then are latched once after reset release
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mode_meta_q <= '0;
      mode_sync_q <= '0;
      start_cnt_q <= '0;
      mode_valid_q <= 1'b0;
      mode_q <= '0;
    end else begin
      mode_meta_q <= MODE_PINS;
      mode_sync_q <= mode_meta_q;
      if (load_init) begin
        mode_valid_q <= 1'b1;
        mode_q <= decode_mode(mode_sync_q);
      end else if (!mode_valid_q) begin
        start_cnt_q <= start_cnt_q + 2'h1;
      end
    end
  end

  assign load_init = !mode_valid_q && (start_cnt_q == START_CYCLES);

  // port e pin levels are asynchronous to the bus clock
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pe_meta_q <= '0;
      pe_sync_q <= '0;
    end else begin
      pe_meta_q <= PE_IN;
      pe_sync_q <= pe_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // wishbone decode
  // ----------------------------------------------------------------
  // requests wait until the mode is known; removed registers answer with err
  assign req = CYC_I && STB_I && !ack_q && !err_q && mode_valid_q;
  assign idx = ADR_I[9:2];
  assign pe_regs_on = !mode_q.periph && !(mode_q.expanded && mc_q[MC_EMULATE]);
  assign hit_pb_dir = (idx == IDX_PORT_B_DIR) && mode_q.single;
  assign hit_sel = (idx == IDX_PIN_FUNC_SEL) && !mode_q.periph;
  assign hit_pe_data = (idx == IDX_PORT_E_DATA) && pe_regs_on;
  assign hit_pe_dir = (idx == IDX_PORT_E_DIR) && pe_regs_on;
  assign hit_mc = (idx == IDX_MODE_CTL);
  assign hit_pair = (idx == IDX_FUNC_MODE_PAIR) && !mode_q.periph;
  assign known = (idx == IDX_PORT_B_DIR) || (idx == IDX_PIN_FUNC_SEL) ||
                 (idx == IDX_PORT_E_DATA) || (idx == IDX_PORT_E_DIR) ||
                 (idx == IDX_FUNC_MODE_PAIR);
  assign mapped = hit_pb_dir || hit_sel || hit_pe_data || hit_pe_dir || hit_mc || hit_pair;
  assign wr = req && mapped && WE_I;

  // one-cycle answer; ack or err drops the cycle after it is given
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      ext_q <= 1'b0;
    end else begin
      ack_q <= req && mapped;
      err_q <= req && !mapped;
      ext_q <= req && !mapped && known;
    end
  end

  // read data captured with the answer
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_q <= '0;
    end else if (req) begin
      rdata_q <= '0;
      if (hit_pb_dir) rdata_q[7:0] <= pb_dir_q;
      if (hit_sel) rdata_q[7:0] <= sel_q & SEL_IMPL_MASK;
      if (hit_pe_data) rdata_q[7:0] <= pe_read;
      if (hit_pe_dir) rdata_q[7:0] <= pe_dir_q;
      if (hit_mc) rdata_q[7:0] <= mc_q;
      if (hit_pair) rdata_q[15:0] <= {sel_q & SEL_IMPL_MASK, mc_q};
    end
  end

  assign ACK_O = ack_q;
  assign ERR_O = err_q;
  assign EXT_ACCESS = ext_q;
  assign DAT_O = rdata_q;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // port b direction, byte lane 0
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pb_dir_q <= BYTE_RST;
    end else if (wr && hit_pb_dir && SEL_I[0]) begin
      pb_dir_q <= DAT_I[7:0];
    end
  end

  // pin function select: mode reset value, then write-limited updates
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sel_q <= BYTE_RST;
      sel_written_q <= 1'b0;
    end else if (load_init) begin
      sel_q <= sel_reset_value(decode_mode(mode_sync_q));
    end else if (wr && hit_sel && SEL_I[0]) begin
      sel_q <= sel_write(sel_q, DAT_I[7:0], sel_written_q, mode_q);
      sel_written_q <= 1'b1;
    end else if (wr && hit_pair && SEL_I[1]) begin
      sel_q <= sel_write(sel_q, DAT_I[15:8], sel_written_q, mode_q);
      sel_written_q <= 1'b1;
    end
  end

  // mode control: emulation, visibility, stretch and pullup enable
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mc_q <= MC_RST;
    end else if (wr && (hit_mc || hit_pair) && SEL_I[0]) begin
      mc_q <= DAT_I[7:0] & MC_IMPL_MASK;
    end
  end

  // port e data latch and direction; bits 1 and 0 stay inputs
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pe_data_q <= BYTE_RST;
      pe_dir_q <= BYTE_RST;
    end else begin
      if (wr && hit_pe_data && SEL_I[0]) begin
        pe_data_q <= DAT_I[7:0];
      end
      if (wr && hit_pe_dir && SEL_I[0]) begin
        pe_dir_q <= DAT_I[7:0] & ~PE_INPUT_ONLY;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin function selection
  // ----------------------------------------------------------------
  // alternate functions per pin, qualified by operating mode
  assign pipe_on = sel_q[SEL_PIPE_OUT] && !mode_q.single;
  assign clk_test_on = sel_q[SEL_CLK_TEST] && !mode_q.single &&
                       !(mode_q.expanded && !mode_q.special);
  assign eclk_on = !sel_q[SEL_NO_ECLK] && (mode_q.expanded ||
                   (mode_q.single && (mc_q[MC_INTERNAL_VISIBILITY] || !mc_q[MC_E_STRETCH_SELECT])));
  assign strobe_on = sel_q[SEL_LOW_STRB] && mode_q.expanded &&
                     !(mode_q.narrow && !mode_q.special);
  assign tag_mode = strobe_on && mode_q.special && TAG_ENABLE;

  always_comb begin
    alt_en = '0;
    alt_out = '0;
    alt_oe = '0;
    alt_en[7] = mode_q.expanded && !sel_q[SEL_NO_DBE];
    alt_out[7] = BUS_CTL.data_en;
    alt_oe[7] = 1'b1;
    alt_en[6] = pipe_on || clk_test_on;
    alt_out[6] = pipe_on ? BUS_CTL.pipe_hi : BUS_CTL.clk_test;
    alt_oe[6] = 1'b1;
    alt_en[5] = pipe_on;
    alt_out[5] = BUS_CTL.pipe_lo;
    alt_oe[5] = 1'b1;
    alt_en[4] = eclk_on;
    alt_out[4] = BUS_CTL.e_clock;
    alt_oe[4] = 1'b1;
    alt_en[3] = strobe_on;
    alt_out[3] = BUS_CTL.low_strobe;
    alt_oe[3] = !tag_mode;
    alt_en[2] = sel_q[SEL_RW_EN] && !mode_q.single;
    alt_out[2] = BUS_CTL.rw;
    alt_oe[2] = 1'b1;
  end

  // per-pin mux: alternate function beats direction bit, gpio otherwise
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      assign pe_oe_d[gi] = mode_valid_q && !PE_INPUT_ONLY[gi] &&
                           (alt_en[gi] ? alt_oe[gi] : pe_dir_q[gi]);
      assign pe_out_d[gi] = alt_en[gi] ? alt_out[gi] : pe_data_q[gi];
      assign pe_read[gi] = (!alt_en[gi] && pe_dir_q[gi]) ? pe_data_q[gi] : pe_sync_q[gi];
    end
  endgenerate

  // registered pin drive, pullups and port b enables
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pe_out_q <= '0;
      pe_oe_q <= '0;
      pe_pull_q <= '0;
      pb_oe_q <= '0;
    end else begin
      pe_out_q <= pe_out_d;
      pe_oe_q <= pe_oe_d;
      pe_pull_q <= (PE_SOFT_PULL & ~pe_oe_d & {8{mc_q[MC_PULLUP]}}) | PE_HARD_PULL;
      pb_oe_q <= (mode_valid_q && mode_q.single) ? pb_dir_q : '0;
    end
  end

  assign PE_OUT = pe_out_q;
  assign PE_OE = pe_oe_q;
  assign PE_PULLUP = pe_pull_q;
  assign PB_DIR_OE = pb_oe_q;

  // ----------------------------------------------------------------
  // instruction tag sampling
  // ----------------------------------------------------------------
  // synced pin 3 low at the falling edge of e gives a one-cycle tag
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      e_prev_q <= 1'b0;
      tag_q <= 1'b0;
    end else begin
      e_prev_q <= BUS_CTL.e_clock;
      tag_q <= tag_mode && e_prev_q && !BUS_CTL.e_clock && !pe_sync_q[3];
    end
  end

  assign LOW_TAG = tag_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  a_int_pins_input: assert property (PE_OE[1:0] == 2'b00)
    else $error("interrupt pins driven");
  a_pb_expanded_off: assert property (mode_valid_q && !mode_q.single |=> PB_DIR_OE == '0)
    else $error("port b driven outside single-chip");
  a_pb_dir_follow: assert property (mode_valid_q && mode_q.single && $stable(pb_dir_q)
                                    |=> PB_DIR_OE == $past(pb_dir_q))
    else $error("port b enable not following direction");
  a_init_value: assert property ($rose(mode_valid_q)
                                 |-> sel_q == sel_reset_value(mode_q))
    else $error("select reset value wrong for mode");
  a_eclk_expanded: assert property (mode_valid_q && mode_q.expanded
                                    |-> !sel_q[SEL_NO_ECLK])
    else $error("no-e-clock set in expanded mode");
  a_once_normal: assert property (wr && hit_sel && !mode_q.special && sel_written_q
                                  |=> ((sel_q ^ $past(sel_q)) & SEL_ONCE_MASK) == '0)
    else $error("second write took effect in normal mode");
  a_first_special: assert property (wr && hit_sel && mode_q.special && !sel_written_q
                                    |=> ((sel_q ^ $past(sel_q)) & SEL_ONCE_MASK) == '0)
    else $error("first write took effect in special mode");
  a_periph_locked: assert property (mode_valid_q && mode_q.periph && !load_init
                                    |=> $stable(sel_q))
    else $error("select changed in peripheral mode");
  a_periph_refused: assert property (req && mode_q.periph && idx == IDX_PIN_FUNC_SEL
                                     |=> ERR_O && !ACK_O)
    else $error("select answered in peripheral mode");
  a_emul_external: assert property (req && mode_q.expanded && mc_q[MC_EMULATE] &&
                                    idx == IDX_PORT_E_DIR |=> ERR_O && EXT_ACCESS)
    else $error("emulated direction register stayed on chip");
  a_pipe_drive: assert property (mode_valid_q && pipe_on |=> PE_OE[6:5] == 2'b11 &&
                                 PE_OUT[6] == $past(BUS_CTL.pipe_hi))
    else $error("pipe status not on pins 6 and 5");
  a_unimpl_zero: assert property (sel_q[1:0] == 2'b00)
    else $error("unimplemented select bits set");
  a_tag_pulse: assert property (tag_mode && e_prev_q && !BUS_CTL.e_clock &&
                                !pe_sync_q[3] |=> LOW_TAG ##1 !LOW_TAG)
    else $error("tag not raised at e fall");

endmodule : port_e_bus_control_pin_assign

/* File: port_e_far_side.sv */
// far-side pin model: resolves the port e wire levels seen by the block
`timescale 1ns/1ns
module port_e_far_side (
  input wire logic mclk,
  input wire logic tag_drive,
  input wire logic [7:0] pe_out,
  input wire logic [7:0] pe_oe,
  input wire logic [7:0] pe_pullup,
  output logic [7:0] pe_in
);
  logic [7:0] last_q = 8'h00;
  // last level, so a floating pin never repeats it
  always @(posedge mclk) begin
    last_q <= pe_in;
  end
  // block drive first, then the tool on pin 3, then pullups, else a toggling pattern
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pe_oe[i]) begin
        pe_in[i] = pe_out[i];
      end else if (i == 3 && tag_drive) begin
        pe_in[i] = 1'b0;
      end else if (pe_pullup[i]) begin
        pe_in[i] = 1'b1;
      end else begin
        pe_in[i] = ~last_q[i];
      end
    end
  end
endmodule : port_e_far_side

/* File: port_e_bus_control_pin_assign_bench.sv */
// self-checking bench for the port e pin function block
`timescale 1ns/1ns
module port_e_bus_control_pin_assign_bench;
  import port_e_ctl_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [31:0] dat_o;
  logic ack, err, ext, low_tag, tag_en = 1'b0;
  logic [2:0] mode = 3'h4;
  bus_ctl_t bus_ctl = '0;
  logic [7:0] pe_in, pe_out, pe_oe, pe_pull, pb_oe, pbv;
  logic [31:0] rnd = 32'h0000_001c;
  logic [10:0] notes[$];
  logic [10:0] note;
  logic tag_win = 1'b0;
  logic e_d = 1'b0;
  logic tag_exp = 1'b0;
  logic [1:0] p3_d = 2'b00;
  int err_count = 0;
  int n_checks = 0;

  port_e_bus_control_pin_assign i_port_e_bus_control_pin_assign (
    .MCLK(mclk), .RESET_N(reset_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
    .SEL_I(sel), .DAT_I(dat_i), .DAT_O(dat_o), .ACK_O(ack), .ERR_O(err), .EXT_ACCESS(ext),
    .MODE_PINS(mode), .BUS_CTL(bus_ctl), .TAG_ENABLE(tag_en), .PE_IN(pe_in),
    .PE_OUT(pe_out), .PE_OE(pe_oe), .PE_PULLUP(pe_pull), .PB_DIR_OE(pb_oe),
    .LOW_TAG(low_tag));
  port_e_far_side i_port_e_far_side (.mclk(mclk), .tag_drive(tag_en), .pe_out(pe_out),
    .pe_oe(pe_oe), .pe_pullup(pe_pull), .pe_in(pe_in));

  // clock and per-cycle random core signals
  initial begin
    forever #5 mclk = ~mclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  always @(posedge mclk) begin
    rnd <= xs(rnd);
    bus_ctl <= bus_ctl_t'(rnd[6:0]);
    tag_en <= rnd[7];
  end

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic end_sim();
    if (err_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim
  // one classic wishbone cycle; the answer is noted for the monitor
  task automatic wb(input logic w, input logic [7:0] idx, input logic [15:0] d,
                    input logic [3:0] s, input logic e, input logic [7:0] x);
    int i;
    @(posedge mclk);
    // refused on-chip registers also flag the would-be external access
    notes.push_back({e && (idx inside {IDX_PORT_B_DIR, IDX_PIN_FUNC_SEL, IDX_PORT_E_DATA,
                     IDX_PORT_E_DIR, IDX_FUNC_MODE_PAIR}), ~w, e, x});
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= s;
    dat_i <= {16'h0000, d};
    for (i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (ack === 1'b1 || err === 1'b1) break;
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    if (i == 20) begin
      err_count++;
      end_sim();
    end
  endtask : wb
  task automatic rst(input logic [2:0] m);
    @(posedge mclk);
    reset_n <= 1'b0;
    mode <= m;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (5) @(posedge mclk);
  endtask : rst
  // takes the oldest note whenever an answer appears
  always @(posedge mclk) begin
    if (ack === 1'b1 || err === 1'b1) begin
      if (notes.size() == 0) begin
        chk("spare answer", 8'h01, 8'h00);
      end else begin
        note = notes.pop_front();
        chk("err", {7'h00, err}, {7'h00, note[8]});
        chk("ext", {7'h00, ext}, {7'h00, note[10]});
        if (note[9]) chk("read data", dat_o[7:0], note[7:0]);
      end
    end
  end
  // expected low-byte tag: e seen falling while the synced pin 3 is low, one cycle late
  always @(posedge mclk) begin
    e_d <= bus_ctl.e_clock;
    p3_d <= {p3_d[0], pe_in[3]};
    tag_exp <= tag_en && e_d && !bus_ctl.e_clock && !p3_d[1];
    if (tag_win) chk("low_tag", {7'h00, low_tag}, {7'h00, tag_exp});
  end

  // main sequence over the operating modes
  initial begin
    rst(3'h4);
    wb(1'b0, IDX_PIN_FUNC_SEL, 16'h0000, 4'h1, 1'b0, SEL_RST_NORM_SINGLE);
    pbv = rnd[7:0];
    wb(1'b1, IDX_PORT_B_DIR, {8'h00, pbv}, 4'h1, 1'b0, 8'h00);
    wb(1'b0, IDX_PORT_B_DIR, 16'h0000, 4'h1, 1'b0, pbv);
    repeat (3) @(posedge mclk);
    chk("pb_oe", pb_oe, pbv);
    wb(1'b1, IDX_PIN_FUNC_SEL, 16'h00ff, 4'h1, 1'b0, 8'h00);
    wb(1'b1, IDX_PIN_FUNC_SEL, 16'h0000, 4'h1, 1'b0, 8'h00);
    wb(1'b0, IDX_PIN_FUNC_SEL, 16'h0000, 4'h1, 1'b0, 8'hfc);
    wb(1'b1, IDX_PORT_E_DIR, 16'h00ff, 4'h1, 1'b0, 8'h00);
    repeat (3) @(posedge mclk);
    chk("pe_oe", pe_oe, 8'hfc);
    chk("pe_pullup", pe_pull, 8'h03);
    wb(1'b1, IDX_PORT_E_DATA, {8'h00, pbv}, 4'h1, 1'b0, 8'h00);
    repeat (3) @(posedge mclk);
    chk("pe_out", pe_out, pbv);
    wb(1'b0, IDX_PORT_E_DATA, 16'h0000, 4'h1, 1'b0, {pbv[7:2], 2'b11});
    wb(1'b0, 8'h20, 16'h0000, 4'h1, 1'b1, 8'h00);
    rst(MP_SPEC_WIDE);
    wb(1'b0, IDX_PIN_FUNC_SEL, 16'h0000, 4'h1, 1'b0, SEL_RST_SPEC_EXP);
    tag_win <= 1'b1;
    repeat (20) @(posedge mclk);
    wb(1'b0, IDX_PORT_B_DIR, 16'h0000, 4'h1, 1'b1, 8'h00);
    wb(1'b1, IDX_PIN_FUNC_SEL, 16'h0000, 4'h1, 1'b0, 8'h00);
    wb(1'b0, IDX_PIN_FUNC_SEL, 16'h0000, 4'h1, 1'b0, 8'h2c);
    tag_win <= 1'b0;
    wb(1'b1, IDX_PIN_FUNC_SEL, 16'h0000, 4'h1, 1'b0, 8'h00);
    repeat (3) @(posedge mclk);
    chk("pipe pins off", {6'h00, pe_oe[6:5]}, 8'h00);
    wb(1'b1, IDX_PIN_FUNC_SEL, 16'h0020, 4'h1, 1'b0, 8'h00);
    repeat (3) @(posedge mclk);
    chk("pipe pins on", {6'h00, pe_oe[6:5]}, 8'h03);
    chk("int pins", {6'h00, pe_oe[1:0]}, 8'h00);
    wb(1'b1, IDX_PORT_E_DATA, 16'h0000, 4'h1, 1'b0, 8'h00);
    wb(1'b1, IDX_MODE_CTL, 16'h0081, 4'h1, 1'b0, 8'h00);
    wb(1'b1, IDX_PORT_E_DATA, 16'h0000, 4'h1, 1'b1, 8'h00);
    wb(1'b0, IDX_PORT_E_DIR, 16'h0000, 4'h1, 1'b1, 8'h00);
    rst(MP_SPEC_SINGLE);
    wb(1'b1, IDX_FUNC_MODE_PAIR, 16'h1000, 4'h3, 1'b0, 8'h00);
    wb(1'b0, IDX_PIN_FUNC_SEL, 16'h0000, 4'h1, 1'b0, 8'h90);
    wb(1'b0, IDX_MODE_CTL, 16'h0000, 4'h1, 1'b0, 8'h00);
    rst(MP_PERIPH);
    wb(1'b0, IDX_PIN_FUNC_SEL, 16'h0000, 4'h1, 1'b1, 8'h00);
    wb(1'b0, IDX_PORT_B_DIR, 16'h0000, 4'h1, 1'b1, 8'h00);
    rst(MP_NORM_WIDE);
    wb(1'b0, IDX_PIN_FUNC_SEL, 16'h0000, 4'h1, 1'b0, SEL_RST_NORM_EXP);
    wb(1'b1, IDX_PIN_FUNC_SEL, 16'h0010, 4'h1, 1'b0, 8'h00);
    wb(1'b0, IDX_PIN_FUNC_SEL, 16'h0000, 4'h1, 1'b0, 8'h00);
    repeat (3) @(posedge mclk);
    end_sim();
  end
endmodule : port_e_bus_control_pin_assign_bench
